/* File: bench/alert_cfg_chk.sv */
/* Port checks for the alert config bank.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module alert_cfg_chk #(
    parameter DATA_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    input wire logic [7:0] fault_event_i,
    input wire logic [3:0] sense_drain_scan_o,
    input wire logic [7:0] fault_alert_mask_o,
    input wire logic alert_pulse_o,
    input wire logic alert_generated_o
);
    // Single domain, checks paused in reset
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    a_read_answer: assert property (
        ce_i && reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
    a_answer_cause: assert property (
        reg_rvalid_o |-> $past(reg_rd_i) && $past(ce_i))
        else $error("answer without read");
    a_reset_defaults: assert property (
        $fell(reset_i) |-> sense_drain_scan_o == 4'hF
        && fault_alert_mask_o == 8'h00) else $error("bad reset value");
    a_scan_write: assert property (
        ce_i && reg_wr_i && reg_addr_i == 8'h14 ##1 ce_i |=>
        {4'h0, sense_drain_scan_o} == ($past(reg_wdata_i, 2) & 8'h0F))
        else $error("scan select not updated");
    a_mask_write: assert property (
        ce_i && reg_wr_i && reg_addr_i == 8'h15 ##1 ce_i |=>
        fault_alert_mask_o == $past(reg_wdata_i, 2))
        else $error("fault mask not updated");
    a_enabled_alert: assert property (
        ce_i && !$past(reg_wr_i) && (fault_event_i & fault_alert_mask_o)
        != 8'h00 |=> alert_pulse_o && alert_generated_o)
        else $error("enabled fault gave no alert");
    a_flag_sticky: assert property (
        alert_generated_o && !(ce_i && reg_wr_i && reg_addr_i == 8'h84
        && !reg_wdata_i[3]) |=> alert_generated_o)
        else $error("alert flag dropped");
    a_flag_source: assert property (
        $rose(alert_generated_o) |-> alert_pulse_o)
        else $error("flag set without alert");
    // Main scenarios reached
    cover property (alert_pulse_o);
    cover property (reg_rvalid_o);
    cover property ($fell(alert_generated_o));
endmodule
bind alert_cfg_bank alert_cfg_chk #(.DATA_W(DATA_W)) alert_cfg_chk_inst (
    .ref_clk_i, .reset_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rvalid_o, .fault_event_i, .sense_drain_scan_o,
    .fault_alert_mask_o, .alert_pulse_o, .alert_generated_o);
`default_nettype wire

/* File: bench/host_model.sv */
/* Management bus host model driving the register port.
   Assumes requests change at the falling clock edge. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic ref_clk_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    // Idle bus at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    // One-cycle write strobe, then scrambled idle values
    task wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(negedge ref_clk_i);
            reg_addr_o = a;
            reg_wdata_o = d;
            reg_wr_o = 1'b1;
            @(negedge ref_clk_i);
            reg_wr_o = 1'b0;
            reg_addr_o = ~a;
            reg_wdata_o = ~d;
        end
    endtask
    // One-cycle read strobe
    task rd(input logic [7:0] a);
        begin
            @(negedge ref_clk_i);
            reg_addr_o = a;
            reg_rd_o = 1'b1;
            @(negedge ref_clk_i);
            reg_rd_o = 1'b0;
            reg_addr_o = ~a;
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/test_adc_channel_select_alert_mask.sv */
/* Self-checking bench for the alert config bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module test_adc_channel_select_alert_mask;
    logic ref_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
    logic board_enable_n_i = 1'b1, nvm_written_i = 1'b0;
    logic [7:0] fault_ev = 8'h00, aux_in_ev = 8'h00, aux_io_ev = 8'h00;
    logic [5:0] main_ev = 6'h00;
    logic [7:0] addr, wdata, rdata, m, e;
    logic wr, rd, rvalid;
    logic [3:0] in_scan, io_scan, pair_scan, sd_scan;
    logic [7:0] fmask, mmask, imask, omask, wv[0:5];
    logic pulse, flag;
    integer seed = 56043, miscompares = 0, check_count = 0, k;
    logic [7:0] exp_q[$]; // Expected read data, oldest first
    host_model host_model_inst (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    alert_cfg_bank alert_cfg_bank_inst (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .ce_i(ce_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .fault_event_i(fault_ev), .main_threshold_event_i(main_ev),
        .nvm_written_i(nvm_written_i), .aux_in_threshold_event_i(aux_in_ev),
        .aux_io_threshold_event_i(aux_io_ev),
        .board_enable_n_i(board_enable_n_i),
        .aux_analog_input_scan_o(in_scan), .aux_analog_io_pin_scan_o(io_scan),
        .pair_scan_o(pair_scan), .sense_drain_scan_o(sd_scan),
        .fault_alert_mask_o(fmask), .main_alert_mask_o(mmask),
        .aux_in_alert_mask_o(imask), .aux_io_alert_mask_o(omask),
        .alert_pulse_o(pulse), .alert_generated_o(flag));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // Note expected value, then read
    task chk(input logic [7:0] a, input logic [7:0] x);
        begin
            exp_q.push_back(x);
            host_model_inst.rd(a);
        end
    endtask
    // Compare a settled output with its expected value
    task look(input logic [7:0] got, input logic [7:0] x);
        begin
            check_count++;
            if (got !== x) begin
                miscompares++;
                $display("wrong value at %0t: %h vs %h", $time, got, x);
            end
        end
    endtask
    // One-cycle event pulse on group g
    task ev(input integer g, input logic [7:0] v);
        begin
            @(negedge ref_clk_i);
            case (g)
                0: fault_ev = v;
                1: {nvm_written_i, main_ev} = v[6:0];
                2: aux_in_ev = v;
                default: aux_io_ev = v;
            endcase
            @(negedge ref_clk_i);
            {fault_ev, nvm_written_i, main_ev} = 15'h0000;
            {aux_in_ev, aux_io_ev} = 16'h0000;
        end
    endtask
    task end_of_test;
        begin
            if (miscompares == 0 && check_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Compare each read answer with the oldest note
    always @(negedge ref_clk_i) if (rvalid === 1'b1) begin
        e = exp_q.pop_front();
        check_count++;
        if (rdata !== e) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, rdata, e);
        end
    end
    // Hang guard
    initial begin
        #20000;
        miscompares++;
        end_of_test;
    end
    initial begin
        repeat (10) @(negedge ref_clk_i);
        reset_i = 1'b0;
        chk(8'h13, 8'hFF);
        chk(8'h14, 8'h0F);
        for (k = 8'h15; k <= 8'h18; k++) chk(k[7:0], 8'h00);
        chk(8'h84, 8'h00);
        // Frozen clock enable drops the write; wait for the answer to end
        @(negedge ref_clk_i);
        ce_i = 1'b0;
        host_model_inst.wr(8'h15, 8'hAA);
        ce_i = 1'b1;
        chk(8'h15, 8'h00);
        for (k = 8'h13; k <= 8'h18; k++) begin
            m = $random(seed);
            wv[k - 8'h13] = m;
            host_model_inst.wr(k[7:0], m);
            chk(k[7:0], m);
        end
        host_model_inst.wr(8'h20, 8'h5A);
        chk(8'h20, 8'h00);
        look({io_scan, in_scan}, wv[0]);
        look({pair_scan, sd_scan}, wv[1]);
        look(fmask, wv[2]);
        look(mmask, wv[3]);
        look(imask, wv[4]);
        look(omask, wv[5]);
        // Masked events stay silent, enabled ones latch the flag
        for (k = 0; k < 4; k++) begin
            m = ($random(seed) | 8'h01) & 8'hFD;
            host_model_inst.wr(8'h15 + k[7:0], m);
            ev(k, ~m);
            look({7'h00, pulse}, 8'h00);
            chk(8'h84, 8'h00);
            ev(k, m);
            look({7'h00, pulse}, 8'h01);
            chk(8'h84, 8'h08);
            host_model_inst.wr(8'h84, 8'h08);
            chk(8'h84, 8'h08);
            host_model_inst.wr(8'h84, 8'h00);
            chk(8'h84, 8'h00);
        end
        host_model_inst.wr(8'h16, 8'h40);
        ev(1, 8'h40);
        chk(8'h84, 8'h08);
        host_model_inst.wr(8'h84, 8'h00);
        host_model_inst.wr(8'h16, 8'h80);
        @(negedge ref_clk_i);
        board_enable_n_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        chk(8'h84, 8'h08);
        look({7'h00, flag}, 8'h01);
        repeat (4) @(negedge ref_clk_i);
        end_of_test;
    end
endmodule
`default_nettype wire

/* File: rtl/alert_cfg_bank.v */
/*
 * Scan channel select and alert enable mask registers of the monitor.
 * Holds six read/write configuration bytes, gates monitor events with
 * the masks into one alert pulse and keeps the sticky alert flag.
 * Assumes an 8-bit register port from the management bus engine on the
 * same clock, and event pulses from fault and ADC logic on this clock.
 * The board enable pin is asynchronous and is synchronised here.
 * Event inputs are one-cycle pulses; a source held high alerts again on
 * every cycle that it stays high while enabled.
 * The host clears the sticky flag by writing zero to its bit; an alert in
 * the same cycle as that clear wins, so no alert is ever lost.
 * While the clock enable is low every register, the pin synchroniser
 * included, holds its value and no request is taken.
 * The enable change detector needs three enabled edges after reset.
 */
`timescale 1ns/1ns
`default_nettype none
`include "alert_cfg_defines.vh"
module alert_cfg_bank #(
    parameter DATA_W = 8
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire ce_i,
    // Register port from the bus engine
    // Reads answer one cycle later; writes land on the strobe edge
    input wire [7:0] reg_addr_i,
    input wire [DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [DATA_W-1:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // Monitor events, one-cycle pulses
    // Each bit lines up with its enable bit in the mask registers
    input wire [7:0] fault_event_i,
    input wire [5:0] main_threshold_event_i,
    input wire nvm_written_i,
    input wire [7:0] aux_in_threshold_event_i,
    input wire [7:0] aux_io_threshold_event_i,
    // Board enable pin, asynchronous
    // Any change of level is an event once the detector is armed
    input wire board_enable_n_i,
    // Scan selections to the conversion sequencer
    // Each follows its select register one cycle later
    output reg [3:0] aux_analog_input_scan_o,
    output reg [3:0] aux_analog_io_pin_scan_o,
    output reg [3:0] pair_scan_o,
    output reg [3:0] sense_drain_scan_o,
    // Masks to the alert logic
    // Copies of the mask registers for the downstream alert logic
    output reg [7:0] fault_alert_mask_o,
    output reg [7:0] main_alert_mask_o,
    output reg [7:0] aux_in_alert_mask_o,
    output reg [7:0] aux_io_alert_mask_o,
    // Alert outputs
    // Pulse per cycle with any enabled event; flag until cleared
    output reg alert_pulse_o,
    output reg alert_generated_o
);
    // Number of maskable event sources
    // Fault 8, enable change 1, memory write 1, main 6, aux in 8, aux io 8
    localparam N_EV = 32;
    // Edges after reset before the enable change detector trusts history
    localparam ARM_STAGES = 3;

    // Address match, used by write and read paths
    function addr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            // Exact byte compare, so no offset aliases another
            addr_hit = (addr == ofs);
        end
    endfunction

    // Configuration registers
    // Scan enables for single-ended inputs and io pins
    reg [7:0] single_select_r;
    // Scan enables for differential pairs, sense and drain
    reg [7:0] pair_select_r;
    // Alert enables for the fault sources
    reg [7:0] fault_mask_r;
    // Alert enables for pin change, memory write and main thresholds
    reg [7:0] main_mask_r;
    // Alert enables for the analog input thresholds
    reg [7:0] aux_in_mask_r;
    // Alert enables for the io pin thresholds
    reg [7:0] aux_io_mask_r;
    // Sticky alert flag and its next value
    reg alert_generated_r;
    reg alert_generated_nxt;
    // Previous synchronised enable level
    reg enable_prev_r;
    // Arming shift register; the detector stays quiet until the
    // synchroniser and the previous level hold real pin samples, since
    // both leave reset low while the idle pin sits high
    reg [ARM_STAGES-1:0] enable_primed_r;
    // Read data mux output
    reg [7:0] read_mux;
    // Read data padded above the byte, cut back to the port width
    wire [DATA_W+7:0] read_pad;

    // Synchronised enable pin level
    // Only the second synchroniser stage is ever read here
    wire enable_level;
    // Enable pin changed state this cycle
    wire enable_changed;
    // Raw event and mask vectors, index order matches each other
    wire [N_EV-1:0] event_vec;
    wire [N_EV-1:0] mask_vec;
    // Per-event enabled hits
    wire [N_EV-1:0] hit_vec;
    // Any enabled event this cycle
    wire any_alert;
    // Host clears the sticky flag this cycle
    wire clear_req;

    // Pin synchroniser for the board enable input
    // The pin is active low; either direction of change is an event
    pin_sync #(
        .WIDTH(1)
    ) u_enable_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .pin_i(board_enable_n_i),
        .level_o(enable_level)
    );

    // Change detect on the synchronised level, quiet until armed
    assign enable_changed = enable_primed_r[ARM_STAGES-1]
        & (enable_level ^ enable_prev_r);

    // Track the last seen enable level
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            // Forget history; arming starts again
            enable_prev_r <= 1'b0;
            enable_primed_r <= {ARM_STAGES{1'b0}};
        end else if (ce_i) begin
            // Keep this level and shift one more arming stage in
            enable_prev_r <= enable_level;
            enable_primed_r <= {enable_primed_r[ARM_STAGES-2:0], 1'b1};
        end
    end

    // Events in register bit order, masks in the same order
    // Bit 31 is the external fault, bit 0 the io pin 4 low threshold
    assign event_vec = {
        fault_event_i,
        enable_changed,
        nvm_written_i,
        main_threshold_event_i,
        aux_in_threshold_event_i,
        aux_io_threshold_event_i
    };
    // Mask bits taken in the same order as the event bits
    assign mask_vec = {
        fault_mask_r,
        main_mask_r,
        aux_in_mask_r,
        aux_io_mask_r
    };

    // Gate each event with its enable bit
    // One gate per source keeps each enable traceable bit by bit
    genvar gi;
    generate
        for (gi = 0; gi < N_EV; gi = gi + 1) begin : g_gate
            assign hit_vec[gi] = event_vec[gi] & mask_vec[gi];
        end
    endgenerate

    // Only enabled events count
    // A disabled source can neither pulse nor set the flag
    assign any_alert = |hit_vec;

    // Writing zero to the flag bit clears it
    // Writing one there leaves the flag alone
    assign clear_req = reg_wr_i
        & addr_hit(reg_addr_i, `OFS_METER_CONTROL)
        & ~reg_wdata_i[`BIT_ALERT_GENERATED];

    // Sticky flag: a new alert wins over a clear in the same cycle
    always @* begin
        // Hold by default
        alert_generated_nxt = alert_generated_r;
        if (any_alert) begin
            // Any enabled event sets the flag
            alert_generated_nxt = 1'b1;
        end else if (clear_req) begin
            // Host clear only takes effect when no enabled event arrives
            alert_generated_nxt = 1'b0;
        end
    end

    // Register writes, decoded per offset
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            // Defaults: every scan on except the pairs, no alerts
            single_select_r <= `RST_SINGLE_SELECT;
            pair_select_r <= `RST_PAIR_SELECT;
            fault_mask_r <= `RST_MASK;
            main_mask_r <= `RST_MASK;
            aux_in_mask_r <= `RST_MASK;
            aux_io_mask_r <= `RST_MASK;
        end else if (ce_i && reg_wr_i) begin
            // Writes to unmapped offsets fall through and change nothing
            if (addr_hit(reg_addr_i, `OFS_SINGLE_SELECT)) begin
                // Io pins high nibble, analog inputs low nibble
                single_select_r <= reg_wdata_i[7:0];
            end else if (addr_hit(reg_addr_i, `OFS_PAIR_SELECT)) begin
                // Differential pairs high nibble, sense and drain low
                pair_select_r <= reg_wdata_i[7:0];
            end else if (addr_hit(reg_addr_i, `OFS_FAULT_MASK)) begin
                // One enable per fault source
                fault_mask_r <= reg_wdata_i[7:0];
            end else if (addr_hit(reg_addr_i, `OFS_MAIN_MASK)) begin
                // Pin change, memory write and main thresholds
                main_mask_r <= reg_wdata_i[7:0];
            end else if (addr_hit(reg_addr_i, `OFS_AUX_IN_MASK)) begin
                // High/low pair per analog input, input 1 on top
                aux_in_mask_r <= reg_wdata_i[7:0];
            end else if (addr_hit(reg_addr_i, `OFS_AUX_IO_MASK)) begin
                // High/low pair per io pin, pin 1 on top
                aux_io_mask_r <= reg_wdata_i[7:0];
            end
        end
    end

    // Read mux; unmapped offsets and foreign bits read as zero
    always @* begin
        read_mux = 8'h00;
        if (addr_hit(reg_addr_i, `OFS_SINGLE_SELECT)) begin
            // Single-ended scan enables
            read_mux = single_select_r;
        end else if (addr_hit(reg_addr_i, `OFS_PAIR_SELECT)) begin
            // Pair, sense and drain scan enables
            read_mux = pair_select_r;
        end else if (addr_hit(reg_addr_i, `OFS_FAULT_MASK)) begin
            // Fault alert enables
            read_mux = fault_mask_r;
        end else if (addr_hit(reg_addr_i, `OFS_MAIN_MASK)) begin
            // Main alert enables
            read_mux = main_mask_r;
        end else if (addr_hit(reg_addr_i, `OFS_AUX_IN_MASK)) begin
            // Analog input alert enables
            read_mux = aux_in_mask_r;
        end else if (addr_hit(reg_addr_i, `OFS_AUX_IO_MASK)) begin
            // Io pin alert enables
            read_mux = aux_io_mask_r;
        end else if (addr_hit(reg_addr_i, `OFS_METER_CONTROL)) begin
            // Only the sticky flag lives here; other bits read zero
            read_mux[`BIT_ALERT_GENERATED] = alert_generated_r;
        end
    end

    // Zero bits above the byte when the data path is wider
    assign read_pad = {{DATA_W{1'b0}}, read_mux};

    // Status, read answer and outputs, all registered
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            // Flag, pulse and read port start idle
            alert_generated_r <= 1'b0;
            alert_generated_o <= 1'b0;
            alert_pulse_o <= 1'b0;
            reg_rdata_o <= {DATA_W{1'b0}};
            reg_rvalid_o <= 1'b0;
            // Scan outputs match the select register defaults
            aux_analog_input_scan_o <= 4'hF;
            aux_analog_io_pin_scan_o <= 4'hF;
            pair_scan_o <= 4'h0;
            sense_drain_scan_o <= 4'hF;
            // Mask outputs match the mask register defaults
            fault_alert_mask_o <= 8'h00;
            main_alert_mask_o <= 8'h00;
            aux_in_alert_mask_o <= 8'h00;
            aux_io_alert_mask_o <= 8'h00;
        end else if (ce_i) begin
            // Flag copy and output both take the same next value
            alert_generated_r <= alert_generated_nxt;
            alert_generated_o <= alert_generated_nxt;
            alert_pulse_o <= any_alert;
            // One answer per read strobe
            reg_rvalid_o <= reg_rd_i;
            // Read data holds its last value between reads
            if (reg_rd_i) begin
                reg_rdata_o <= read_pad[DATA_W-1:0];
            end
            // Scan selections follow the select registers
            aux_analog_input_scan_o <= single_select_r[3:0];
            aux_analog_io_pin_scan_o <= single_select_r[7:4];
            pair_scan_o <= pair_select_r[7:4];
            sense_drain_scan_o <= pair_select_r[3:0];
            // Masks follow the mask registers
            fault_alert_mask_o <= fault_mask_r;
            main_alert_mask_o <= main_mask_r;
            aux_in_alert_mask_o <= aux_in_mask_r;
            aux_io_alert_mask_o <= aux_io_mask_r;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/alert_cfg_defines.vh */
/*
 * Constants for the scan select and alert mask register bank.
 * Assumes an 8-bit register port driven by the management bus engine.
 */
`ifndef ALERT_CFG_DEFINES_VH
`define ALERT_CFG_DEFINES_VH

// Register offsets
`define OFS_SINGLE_SELECT 8'h13
`define OFS_PAIR_SELECT 8'h14
`define OFS_FAULT_MASK 8'h15
`define OFS_MAIN_MASK 8'h16
`define OFS_AUX_IN_MASK 8'h17
`define OFS_AUX_IO_MASK 8'h18
`define OFS_METER_CONTROL 8'h84

// Reset values
`define RST_SINGLE_SELECT 8'hFF
`define RST_PAIR_SELECT 8'h0F
`define RST_MASK 8'h00

// Field positions
`define BIT_ENABLE_CHANGED 7
`define BIT_NVM_WRITTEN 6
`define BIT_ALERT_GENERATED 3

// Synchroniser depth for pin inputs
`define SYNC_STAGES 2

`endif

/* File: rtl/pin_sync.v */
/*
 * Two-stage synchroniser for asynchronous pin levels.
 * Assumes the input is a slow level; no pulse stretching is done.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter WIDTH = 1
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire ce_i,
    input wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] level_o
);
    // First stage, read only by the second stage
    reg [WIDTH-1:0] meta_r;
    // Second stage, safe to use
    reg [WIDTH-1:0] stable_r;

    // Shift the pin through both stages
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_r <= {WIDTH{1'b0}};
            stable_r <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            meta_r <= pin_i;
            stable_r <= meta_r;
        end
    end

    assign level_o = stable_r;
endmodule
`default_nettype wire
